// ---- dmad_datapath.sv ----
// dmad_datapath: data move and arithmetic execution datapath.
// assumes a decoder drives one command per start pulse while busy is low,
// and a memory that answers each mem_req with one mem_ack cycle.
// How it works
// RULE1: eight registers, byte word long views alias
// RULE2: moves register, memory, immediate at B/W/L
// RULE3: peripheral moves refused as illegal
// RULE4: pop reads at stack, then increments
// RULE5: push decrements stack, then writes
// RULE6: add/sub with register or immediate source
// RULE7: byte subtract of immediate is refused
// RULE8: carry ops are byte only, use carry
// RULE9: inc/dec by one or two
// RULE10: byte inc/dec step two refused
// RULE11: small add/sub of 1,2,4 on longs
// RULE12: decimal adjust byte using carry, half-carry
// RULE13: unsigned 8x8 or 16x16 multiply
// RULE14: signed 8x8 or 16x16 multiply
// RULE15: immediates and offsets 3, 8, 16, 24 bits
// RULE16: flags negative, zero, overflow, carry held
// RULE17: arithmetic updates flags at operand size
`timescale 1ns/10ps
`default_nettype none
module dmad_datapath (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // command
  input wire logic start,
  input wire dmad_pkg::dmad_op_t op,
  input wire dmad_pkg::dmad_size_t size,
  input wire logic [3:0] rd_code,
  input wire logic [3:0] rs_code,
  input wire logic use_imm,
  input wire logic [31:0] imm,
  input wire dmad_pkg::dmad_ilen_t imm_len,
  input wire logic [2:0] base_idx,
  input wire dmad_pkg::dmad_am_t am,
  // memory
  output logic mem_req,
  output logic mem_we,
  output dmad_pkg::dmad_size_t mem_size,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  // status
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [31:0] result,
  output logic flag_h,
  output logic flag_n,
  output logic flag_z,
  output logic flag_v,
  output logic flag_c
);

  typedef struct packed {
    dmad_pkg::dmad_st_t st;
    dmad_pkg::dmad_op_t op;
    dmad_pkg::dmad_size_t size;
    logic [3:0] rd;
    logic [2:0] base;
    dmad_pkg::dmad_am_t am;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic mem_req;
    logic mem_we;
    logic busy;
    logic done;
    logic illegal;
    logic [31:0] result;
    logic h;
    logic n;
    logic z;
    logic v;
    logic c;
  } dmad_dp_t;

  dmad_dp_t q;
  dmad_dp_t next_q;

  logic idle_start;
  logic bad;
  logic is_load;
  logic [31:0] imm_v;
  logic [31:0] a_data;
  logic [31:0] b_data;
  logic [31:0] base_data;
  logic [31:0] alu_b;
  logic [31:0] alu_res;
  logic [3:0] a_code;
  dmad_pkg::dmad_size_t a_size;
  logic [2:0] rd_base;
  logic wr_en;
  logic [3:0] wr_code;
  dmad_pkg::dmad_size_t wr_size;
  logic [31:0] wr_data;
  logic ah;
  logic an;
  logic az;
  logic av;
  logic ac;

  // ==========================================================
  // command decode
  assign idle_start = start && (q.st == dmad_pkg::ST_IDLE);
  assign bad = dmad_pkg::is_illegal(op, size, use_imm, imm);
  // displacements are signed, all other fields zero-extend
  assign imm_v = dmad_pkg::imm_ext(imm, imm_len, am == dmad_pkg::AM_DISP); // RULE15
  assign is_load = (q.op == dmad_pkg::OP_MOVE_LD) || (q.op == dmad_pkg::OP_POP);
  assign a_code = (q.st == dmad_pkg::ST_IDLE) ? rd_code : q.rd;
  assign a_size = (op == dmad_pkg::OP_MUL_U || op == dmad_pkg::OP_MUL_S) ?
                  dmad_pkg::widen(size) : size;
  assign rd_base = (q.st != dmad_pkg::ST_IDLE) ? q.base :
                   (op == dmad_pkg::OP_PUSH || op == dmad_pkg::OP_POP) ?
                   dmad_pkg::SP_IDX : base_idx;
  assign alu_b = use_imm ? imm_v : b_data; // RULE6

  dmad_regfile u_rf (
    .clk(clk),
    .rst_n(rst_n),
    .a_code(a_code),
    .a_size(a_size),
    .a_data(a_data),
    .b_code(rs_code),
    .b_size(size),
    .b_data(b_data),
    .base_idx(rd_base),
    .base_data(base_data),
    .wr_en(wr_en),
    .wr_code(wr_code),
    .wr_size(wr_size),
    .wr_data(wr_data)
  );

  dmad_alu u_alu (
    .op(op),
    .size(size),
    .a(a_data),
    .b(alu_b),
    .h_in(q.h),
    .n_in(q.n),
    .z_in(q.z),
    .v_in(q.v),
    .c_in(q.c),
    .res(alu_res),
    .h_out(ah),
    .n_out(an),
    .z_out(az),
    .v_out(av),
    .c_out(ac)
  );

  // ==========================================================
  // sequencing
  always_comb begin
    logic [31:0] ld;
    next_q = q;
    next_q.done = 1'b0;
    next_q.illegal = 1'b0;
    wr_en = 1'b0;
    wr_code = q.rd;
    wr_size = q.size;
    wr_data = 32'h0000_0000;
    ld = mem_rdata & dmad_pkg::size_mask(q.size);
    case (q.st)
      dmad_pkg::ST_IDLE: begin
        if (start && bad) begin
          next_q.illegal = 1'b1; // RULE3 RULE7 RULE10
          next_q.done = 1'b1;
        end else if (start) begin
          next_q.op = op;
          next_q.size = size;
          next_q.rd = rd_code;
          next_q.base = rd_base;
          next_q.am = (op == dmad_pkg::OP_POP) ? dmad_pkg::AM_POST_INC :
                      (op == dmad_pkg::OP_PUSH) ? dmad_pkg::AM_PRE_DEC : am;
          case (op)
            dmad_pkg::OP_MOVE_LD, dmad_pkg::OP_MOVE_ST, dmad_pkg::OP_POP,
            dmad_pkg::OP_PUSH: begin
              case (next_q.am)
                dmad_pkg::AM_DISP: next_q.addr = base_data + imm_v;
                dmad_pkg::AM_PRE_DEC: next_q.addr = base_data - dmad_pkg::step_of(size);
                dmad_pkg::AM_ABS: next_q.addr = imm_v;
                default: next_q.addr = base_data;
              endcase
              if (next_q.am == dmad_pkg::AM_PRE_DEC) begin
                wr_en = 1'b1; // RULE5
                wr_code = {1'b0, rd_base};
                wr_size = dmad_pkg::SZ_L;
                wr_data = next_q.addr;
              end
              next_q.wdata = b_data; // RULE2
              next_q.mem_we = (op == dmad_pkg::OP_MOVE_ST) || (op == dmad_pkg::OP_PUSH);
              next_q.mem_req = 1'b1;
              next_q.busy = 1'b1;
              next_q.st = dmad_pkg::ST_MEM;
            end
            default: begin
              wr_en = 1'b1; // RULE6 RULE9 RULE11 RULE12
              wr_code = rd_code;
              wr_size = a_size; // RULE13 RULE14
              wr_data = alu_res;
              next_q.result = alu_res;
              next_q.h = ah; // RULE16
              next_q.n = an;
              next_q.z = az;
              next_q.v = av;
              next_q.c = ac;
              next_q.done = 1'b1;
            end
          endcase
        end
      end
      dmad_pkg::ST_MEM: begin
        if (mem_ack) begin
          next_q.mem_req = 1'b0;
          next_q.mem_we = 1'b0;
          if (is_load) begin
            wr_en = 1'b1; // RULE2 RULE4
            wr_data = ld;
            next_q.result = ld;
            next_q.n = ld[dmad_pkg::msb_idx(q.size)];
            next_q.z = (ld == 32'h0000_0000);
            next_q.v = 1'b0;
          end else begin
            next_q.result = q.wdata;
          end
          if (q.am == dmad_pkg::AM_POST_INC) begin
            next_q.st = dmad_pkg::ST_POST;
          end else begin
            next_q.st = dmad_pkg::ST_IDLE;
            next_q.busy = 1'b0;
            next_q.done = 1'b1;
          end
        end
      end
      dmad_pkg::ST_POST: begin
        // increment after the data write, so a pop into the pointer still steps it
        wr_en = 1'b1; // RULE4
        wr_code = {1'b0, q.base};
        wr_size = dmad_pkg::SZ_L;
        wr_data = base_data + dmad_pkg::step_of(q.size);
        next_q.st = dmad_pkg::ST_IDLE;
        next_q.busy = 1'b0;
        next_q.done = 1'b1;
      end
      default: begin
        next_q.st = dmad_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign mem_req = q.mem_req;
  assign mem_we = q.mem_we;
  assign mem_size = q.size;
  assign mem_addr = q.addr;
  assign mem_wdata = q.wdata;
  assign busy = q.busy;
  assign done = q.done;
  assign illegal = q.illegal;
  assign result = q.result;
  assign flag_h = q.h;
  assign flag_n = q.n;
  assign flag_z = q.z;
  assign flag_v = q.v;
  assign flag_c = q.c;

  // ==========================================================
  // checks
  logic [7:0] exp_addc;
  logic [15:0] exp_mulu;
  assign exp_addc = a_data[7:0] + alu_b[7:0] + {7'h00, q.c};
  assign exp_mulu = {8'h00, a_data[7:0]} * {8'h00, b_data[7:0]};

  property p_periph_refused;
    @(posedge clk) disable iff (!rst_n)
    idle_start && (op == dmad_pkg::OP_PERIPH_FROM || op == dmad_pkg::OP_PERIPH_TO)
    |=> illegal && done && !mem_req;
  endproperty
  a_periph_refused: assert property (p_periph_refused) else $error("peripheral move taken"); // RULE3

  property p_sub_imm_byte;
    @(posedge clk) disable iff (!rst_n)
    idle_start && op == dmad_pkg::OP_SUB && size == dmad_pkg::SZ_B && use_imm
    |=> illegal && $stable(result);
  endproperty
  a_sub_imm_byte: assert property (p_sub_imm_byte) else $error("byte sub of immediate"); // RULE7

  property p_inc_byte_two;
    @(posedge clk) disable iff (!rst_n)
    idle_start && op == dmad_pkg::OP_INC && size == dmad_pkg::SZ_B &&
    imm == dmad_pkg::STEP_2 |=> illegal;
  endproperty
  a_inc_byte_two: assert property (p_inc_byte_two) else $error("byte step of two taken"); // RULE10

  property p_small_long_only;
    @(posedge clk) disable iff (!rst_n)
    idle_start && op == dmad_pkg::OP_ADD_SMALL && size != dmad_pkg::SZ_L |=> illegal;
  endproperty
  a_small_long_only: assert property (p_small_long_only) else $error("short small add"); // RULE11

  property p_push_predec;
    @(posedge clk) disable iff (!rst_n)
    idle_start && op == dmad_pkg::OP_PUSH && !bad
    |=> mem_req && mem_we && mem_addr == $past(base_data) - dmad_pkg::step_of(mem_size);
  endproperty
  a_push_predec: assert property (p_push_predec) else $error("push address wrong"); // RULE5

  property p_pop_postinc;
    @(posedge clk) disable iff (!rst_n)
    q.st == dmad_pkg::ST_MEM && mem_ack && q.op == dmad_pkg::OP_POP
    |=> busy && !done ##1 done && !busy;
  endproperty
  a_pop_postinc: assert property (p_pop_postinc) else $error("pop step missing"); // RULE4

  property p_add_carry;
    @(posedge clk) disable iff (!rst_n)
    idle_start && op == dmad_pkg::OP_ADD_C && !bad
    |=> result[7:0] == $past(exp_addc) && done;
  endproperty
  a_add_carry: assert property (p_add_carry) else $error("carry add wrong"); // RULE8

  property p_mul_u;
    @(posedge clk) disable iff (!rst_n)
    idle_start && op == dmad_pkg::OP_MUL_U && size == dmad_pkg::SZ_B
    |=> result == {16'h0000, $past(exp_mulu)};
  endproperty
  a_mul_u: assert property (p_mul_u) else $error("unsigned product wrong"); // RULE13

  property p_zero_flag;
    @(posedge clk) disable iff (!rst_n)
    idle_start && op == dmad_pkg::OP_ADD && !bad |=> flag_z == (result == 32'h0000_0000);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RULE17

endmodule
`default_nettype wire

// ---- dmad_pkg.sv ----
// dmad_pkg: shared types, constants and decode helpers of the datapath.
// assumes every file refers to it as dmad_pkg::name, never by import.
package dmad_pkg;

  // ==========================================================
  // enumerations
  typedef enum logic [4:0] {
    OP_MOVE_RR, OP_MOVE_IMM, OP_MOVE_LD, OP_MOVE_ST, OP_POP, OP_PUSH,
    OP_PERIPH_FROM, OP_PERIPH_TO, OP_ADD, OP_SUB, OP_ADD_C, OP_SUB_B,
    OP_INC, OP_DEC, OP_ADD_SMALL, OP_SUB_SMALL, OP_DADJ_ADD, OP_DADJ_SUB,
    OP_MUL_U, OP_MUL_S
  } dmad_op_t;
  typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} dmad_size_t;
  typedef enum logic [2:0] {AM_IND, AM_DISP, AM_POST_INC, AM_PRE_DEC, AM_ABS} dmad_am_t;
  typedef enum logic [2:0] {IL_3, IL_8, IL_16, IL_24, IL_32} dmad_ilen_t;
  typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_POST} dmad_st_t;

  // ==========================================================
  // constants
  localparam logic [2:0] SP_IDX = 3'h7;
  localparam int CODE_SEL_BIT = 3;
  localparam logic [31:0] MASK_3 = 32'h0000_0007;
  localparam logic [31:0] MASK_B = 32'h0000_00FF;
  localparam logic [31:0] MASK_W = 32'h0000_FFFF;
  localparam logic [31:0] MASK_24 = 32'h00FF_FFFF;
  localparam logic [31:0] MASK_L = 32'hFFFF_FFFF;
  localparam int MSB_B = 7;
  localparam int MSB_W = 15;
  localparam int MSB_L = 31;
  localparam int HC_B = 4;
  localparam int HC_W = 12;
  localparam int HC_L = 28;
  localparam logic [31:0] STEP_1 = 32'h0000_0001;
  localparam logic [31:0] STEP_2 = 32'h0000_0002;
  localparam logic [31:0] STEP_4 = 32'h0000_0004;
  localparam logic [3:0] NIB_MAX = 4'h9;
  localparam logic [7:0] BCD_MAX = 8'h99;
  localparam logic [7:0] ADJ_LO = 8'h06;
  localparam logic [7:0] ADJ_HI = 8'h60;

  // ==========================================================
  // helpers
  function automatic logic [31:0] size_mask(input dmad_size_t s);
    case (s)
      SZ_B: size_mask = MASK_B;
      SZ_W: size_mask = MASK_W;
      default: size_mask = MASK_L;
    endcase
  endfunction

  function automatic int msb_idx(input dmad_size_t s);
    case (s)
      SZ_B: msb_idx = MSB_B;
      SZ_W: msb_idx = MSB_W;
      default: msb_idx = MSB_L;
    endcase
  endfunction

  function automatic logic [31:0] step_of(input dmad_size_t s);
    case (s)
      SZ_B: step_of = STEP_1;
      SZ_W: step_of = STEP_2;
      default: step_of = STEP_4;
    endcase
  endfunction

  // multiply destination is twice the operand width
  function automatic dmad_size_t widen(input dmad_size_t s);
    widen = (s == SZ_B) ? SZ_W : SZ_L;
  endfunction

  function automatic logic [31:0] imm_ext(input logic [31:0] v, input dmad_ilen_t l,
                                          input logic sx);
    logic [31:0] m;
    logic sgn;
    case (l)
      IL_3: m = MASK_3;
      IL_8: m = MASK_B;
      IL_16: m = MASK_W;
      IL_24: m = MASK_24;
      default: m = MASK_L;
    endcase
    sgn = sx & |(v & m & ~(m >> 1));
    imm_ext = sgn ? (v | ~m) : (v & m);
  endfunction

  function automatic logic is_illegal(input dmad_op_t o, input dmad_size_t s,
                                      input logic use_imm, input logic [31:0] st);
    case (o)
      OP_PERIPH_FROM, OP_PERIPH_TO: is_illegal = 1'b1;
      OP_POP, OP_PUSH: is_illegal = (s == SZ_B);
      OP_SUB: is_illegal = (s == SZ_B) && use_imm;
      OP_ADD_C, OP_SUB_B, OP_DADJ_ADD, OP_DADJ_SUB: is_illegal = (s != SZ_B);
      OP_INC, OP_DEC: is_illegal = !((st == STEP_1) || (st == STEP_2 && s != SZ_B));
      OP_ADD_SMALL, OP_SUB_SMALL:
        is_illegal = (s != SZ_L) || !(st == STEP_1 || st == STEP_2 || st == STEP_4);
      OP_MUL_U, OP_MUL_S: is_illegal = (s == SZ_L);
      default: is_illegal = 1'b0;
    endcase
  endfunction

endpackage

// ---- dmad_regfile.sv ----
// dmad_regfile: eight 32-bit general registers with byte, word and long views.
// assumes one write per clock; reads are combinational.
`timescale 1ns/10ps
`default_nettype none
module dmad_regfile (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // read port a
  input wire logic [3:0] a_code,
  input wire dmad_pkg::dmad_size_t a_size,
  output logic [31:0] a_data,
  // read port b
  input wire logic [3:0] b_code,
  input wire dmad_pkg::dmad_size_t b_size,
  output logic [31:0] b_data,
  // address base, always the long view
  input wire logic [2:0] base_idx,
  output logic [31:0] base_data,
  // write port
  input wire logic wr_en,
  input wire logic [3:0] wr_code,
  input wire dmad_pkg::dmad_size_t wr_size,
  input wire logic [31:0] wr_data
);

  typedef struct packed {
    logic [7:0][31:0] r;
  } dmad_rf_t;

  dmad_rf_t q;
  dmad_rf_t next_q;

  // ==========================================================
  // views all alias one storage word
  function automatic logic [31:0] view(input logic [7:0][31:0] r, input logic [3:0] c,
                                       input dmad_pkg::dmad_size_t s);
    logic [31:0] w;
    w = r[c[2:0]];
    case (s)
      dmad_pkg::SZ_B: view = c[dmad_pkg::CODE_SEL_BIT] ? {24'h00_0000, w[7:0]}
                                                       : {24'h00_0000, w[15:8]};
      dmad_pkg::SZ_W: view = c[dmad_pkg::CODE_SEL_BIT] ? {16'h0000, w[31:16]}
                                                       : {16'h0000, w[15:0]};
      default: view = w;
    endcase
  endfunction

  assign a_data = view(q.r, a_code, a_size); // RULE1
  assign b_data = view(q.r, b_code, b_size); // RULE1
  assign base_data = q.r[base_idx];

  always_comb begin
    logic [31:0] w;
    w = q.r[wr_code[2:0]];
    next_q = q;
    case (wr_size)
      dmad_pkg::SZ_B: begin
        if (wr_code[dmad_pkg::CODE_SEL_BIT]) begin
          w[7:0] = wr_data[7:0];
        end else begin
          w[15:8] = wr_data[7:0];
        end
      end
      dmad_pkg::SZ_W: begin
        if (wr_code[dmad_pkg::CODE_SEL_BIT]) begin
          w[31:16] = wr_data[15:0];
        end else begin
          w[15:0] = wr_data[15:0];
        end
      end
      default: w = wr_data;
    endcase
    if (wr_en) begin
      next_q.r[wr_code[2:0]] = w; // RULE1
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

endmodule
`default_nettype wire

// ---- dmad_alu.sv ----
// dmad_alu: combinational add, subtract, step, decimal adjust and multiply.
// assumes operands arrive zero-extended to 32 bits at the operand size.
`timescale 1ns/10ps
`default_nettype none
module dmad_alu (
  // operation
  input wire dmad_pkg::dmad_op_t op,
  input wire dmad_pkg::dmad_size_t size,
  input wire logic [31:0] a,
  input wire logic [31:0] b,
  // flags in
  input wire logic h_in,
  input wire logic n_in,
  input wire logic z_in,
  input wire logic v_in,
  input wire logic c_in,
  // result and flags out
  output logic [31:0] res,
  output logic h_out,
  output logic n_out,
  output logic z_out,
  output logic v_out,
  output logic c_out
);

  always_comb begin
    logic [31:0] m;
    logic [31:0] am;
    logic [31:0] bx;
    logic [32:0] sum;
    logic [32:0] cv;
    logic sub;
    logic cin;
    logic hi;
    logic lo;
    logic sx;
    logic [15:0] prod;
    logic [31:0] prodw;
    int t;
    int hc;
    m = dmad_pkg::size_mask(size);
    sx = (op == dmad_pkg::OP_MUL_S);
    t = dmad_pkg::msb_idx(size);
    hc = (size == dmad_pkg::SZ_B) ? dmad_pkg::HC_B :
         (size == dmad_pkg::SZ_W) ? dmad_pkg::HC_W : dmad_pkg::HC_L;
    sub = (op == dmad_pkg::OP_SUB) || (op == dmad_pkg::OP_SUB_B) ||
          (op == dmad_pkg::OP_DEC) || (op == dmad_pkg::OP_SUB_SMALL);
    cin = (op == dmad_pkg::OP_ADD_C) ? c_in : (op == dmad_pkg::OP_SUB_B) ? ~c_in : sub; // RULE8
    am = a & m;
    bx = sub ? (~b & m) : (b & m);
    sum = {1'b0, am} + {1'b0, bx} + {32'h0000_0000, cin};
    cv = {1'b0, am} ^ {1'b0, bx} ^ sum;
    res = sum[31:0] & m;
    h_out = h_in;
    n_out = n_in;
    z_out = z_in;
    v_out = v_in;
    c_out = c_in;
    prod = 16'h0000;
    prodw = 32'h0000_0000;
    hi = 1'b0;
    lo = 1'b0;
    case (op)
      dmad_pkg::OP_ADD, dmad_pkg::OP_SUB, dmad_pkg::OP_ADD_C, dmad_pkg::OP_SUB_B: begin
        h_out = cv[hc] ^ sub; // RULE17
        c_out = sum[t + 1] ^ sub; // RULE17
        n_out = res[t]; // RULE17
        v_out = (am[t] == bx[t]) && (res[t] != am[t]); // RULE17
        // carry chains keep zero only if every piece was zero
        z_out = (res == 32'h0000_0000) &&
                ((op != dmad_pkg::OP_ADD_C && op != dmad_pkg::OP_SUB_B) || z_in); // RULE17
      end
      dmad_pkg::OP_INC, dmad_pkg::OP_DEC: begin
        n_out = res[t]; // RULE9
        z_out = (res == 32'h0000_0000);
        v_out = (am[t] == bx[t]) && (res[t] != am[t]);
      end
      dmad_pkg::OP_ADD_SMALL, dmad_pkg::OP_SUB_SMALL: begin
        res = sum[31:0]; // RULE11
      end
      dmad_pkg::OP_DADJ_ADD: begin
        lo = h_in || (a[3:0] > dmad_pkg::NIB_MAX);
        hi = c_in || (a[7:0] > dmad_pkg::BCD_MAX);
        res = {24'h00_0000, a[7:0] + (hi ? dmad_pkg::ADJ_HI : 8'h00) +
               (lo ? dmad_pkg::ADJ_LO : 8'h00)}; // RULE12
        c_out = hi;
        n_out = res[dmad_pkg::MSB_B];
        z_out = (res == 32'h0000_0000);
      end
      dmad_pkg::OP_DADJ_SUB: begin
        res = {24'h00_0000, a[7:0] - (c_in ? dmad_pkg::ADJ_HI : 8'h00) -
               (h_in ? dmad_pkg::ADJ_LO : 8'h00)}; // RULE12
        n_out = res[dmad_pkg::MSB_B];
        z_out = (res == 32'h0000_0000);
      end
      dmad_pkg::OP_MUL_U, dmad_pkg::OP_MUL_S: begin
        if (size == dmad_pkg::SZ_B) begin
          prod = {{8{sx & a[7]}}, a[7:0]} * {{8{sx & b[7]}}, b[7:0]}; // RULE13 RULE14
          res = {16'h0000, prod};
          n_out = sx ? prod[dmad_pkg::MSB_W] : n_in;
        end else begin
          prodw = {{16{sx & a[15]}}, a[15:0]} * {{16{sx & b[15]}}, b[15:0]}; // RULE13 RULE14
          res = prodw;
          n_out = sx ? prodw[dmad_pkg::MSB_L] : n_in;
        end
        z_out = sx ? (res == 32'h0000_0000) : z_in;
      end
      default: begin
        // plain moves pass b through
        res = b & m; // RULE2
        n_out = res[t];
        z_out = (res == 32'h0000_0000);
        v_out = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// ---- dmad_datapath_tb.sv ----
// dmad_datapath_tb: self-checking bench for the data move and arithmetic datapath.
// assumes dmad_pkg compiled first; memory is modelled here with a random ack delay.
`timescale 1ns/10ps
`default_nettype none
module dmad_datapath_tb;
  // ==========================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic start = 1'b0;
  dmad_pkg::dmad_op_t op = dmad_pkg::OP_MOVE_RR;
  dmad_pkg::dmad_size_t size = dmad_pkg::SZ_L;
  logic [3:0] rd_code = 4'h0;
  logic [3:0] rs_code = 4'h0;
  logic use_imm = 1'b0;
  logic [31:0] imm = 32'h0000_0000;
  dmad_pkg::dmad_ilen_t imm_len = dmad_pkg::IL_32;
  logic [2:0] base_idx = 3'h7;
  dmad_pkg::dmad_am_t am = dmad_pkg::AM_IND;
  logic [31:0] mem_rdata = 32'h0000_0000;
  logic mem_ack = 1'b0;
  logic mem_req, mem_we, busy, done, illegal, flag_h, flag_n, flag_z, flag_v, flag_c;
  logic [31:0] mem_addr, mem_wdata, result, rnd, exp_addr, pop_data;
  logic [1:0] mem_size;
  logic [2:0] exp_we;
  logic [34:0] q[$];
  logic [34:0] e_mon;
  int err_count = 0;
  int n_checks = 0;
  int w = 0;

  always #20 clk = ~clk;

  dmad_datapath u_dut (.clk(clk), .rst_n(rst_n), .start(start), .op(op), .size(size),
    .rd_code(rd_code), .rs_code(rs_code), .use_imm(use_imm), .imm(imm), .imm_len(imm_len),
    .base_idx(base_idx), .am(am), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .busy(busy), .done(done), .illegal(illegal), .result(result), .flag_h(flag_h),
    .flag_n(flag_n), .flag_z(flag_z), .flag_v(flag_v), .flag_c(flag_c));

  // ==========================================================
  // checking
  task automatic chk(string what, logic [31:0] e, logic [31:0] s);
    n_checks++;
    if (e !== s) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // note layout: [34] check carry, [33] carry, [32] refused, [31:0] result
  always @(posedge clk) begin
    if (done === 1'b1) begin
      if (q.size() == 0) chk("spare done", 32'h0, 32'h1);
      else begin
        e_mon = q.pop_front();
        chk("illegal", {31'h0, e_mon[32]}, {31'h0, illegal});
        // a refused command leaves result alone, so only the flag is judged
        if (!e_mon[32]) chk("result", e_mon[31:0], result);
        if (e_mon[34]) chk("carry", {31'h0, e_mon[33]}, {31'h0, flag_c});
      end
    end
  end

  // ==========================================================
  // memory: random wait, read data scrambled outside the ack cycle
  always @(posedge clk) begin
    mem_ack <= mem_req === 1'b1 && !mem_ack && w == 0;
    mem_rdata <= (mem_req === 1'b1 && !mem_ack && w == 0) ? pop_data : ~mem_rdata;
    if (mem_req === 1'b1 && !mem_ack) begin
      if (w == 0) begin
        w <= $urandom_range(3);
        chk("mem_addr", exp_addr, mem_addr);
        chk("mem_we_size", {29'h0, exp_we}, {29'h0, mem_we, mem_size});
      end else w <= w - 1;
    end
  end

  // ==========================================================
  // driver
  task automatic c(dmad_pkg::dmad_op_t o, logic [1:0] s, logic [3:0] d, logic [3:0] r,
                   logic u, logic [31:0] i, logic [34:0] e);
    int n;
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    size <= dmad_pkg::dmad_size_t'(s);
    rd_code <= d;
    rs_code <= r;
    use_imm <= u;
    imm <= i;
    imm_len <= s[1] ? dmad_pkg::IL_32 : dmad_pkg::dmad_ilen_t'({1'b0, s} + 3'h1);
    q.push_back(e);
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 40; n++) begin
      #1;
      if (done === 1'b1) break;
      @(posedge clk);
    end
    if (n == 40) begin
      chk("timeout", 32'h0, 32'h1);
      end_sim();
    end
  endtask

  task automatic ml(logic [3:0] d, logic [31:0] v);
    c(dmad_pkg::OP_MOVE_IMM, 2'h2, d, 4'h0, 1'b1, v, {3'h0, v});
  endtask

  initial begin
    void'($urandom(32'hdb5f));
    rnd = $urandom();
    exp_we = 3'h0;
    exp_addr = 32'h0;
    pop_data = 32'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    ml(4'h1, rnd);
    c(dmad_pkg::OP_MOVE_IMM, 2'h0, 4'h9, 4'h0, 1'b1, 32'h5a, 35'h5a);
    c(dmad_pkg::OP_MOVE_IMM, 2'h0, 4'h1, 4'h0, 1'b1, 32'ha5, 35'ha5);
    c(dmad_pkg::OP_MOVE_RR, 2'h2, 4'h3, 4'h1, 1'b0, 32'h0, {3'h0, rnd[31:16], 16'ha55a});
    c(dmad_pkg::OP_MOVE_IMM, 2'h1, 4'hb, 4'h0, 1'b1, 32'h1234, 35'h1234);
    c(dmad_pkg::OP_MOVE_RR, 2'h2, 4'h6, 4'h3, 1'b0, 32'h0, 35'h0_1234_a55a);
    $display("test register views done");
    c(dmad_pkg::OP_MOVE_IMM, 2'h0, 4'ha, 4'h0, 1'b1, 32'hff, 35'hff);
    c(dmad_pkg::OP_ADD, 2'h0, 4'ha, 4'h0, 1'b1, 32'h1, 35'h6_0000_0000);
    c(dmad_pkg::OP_ADD_C, 2'h0, 4'ha, 4'h0, 1'b1, 32'h0, 35'h4_0000_0001);
    c(dmad_pkg::OP_SUB, 2'h2, 4'h6, 4'h0, 1'b1, 32'h1, 35'h0_1234_a559);
    c(dmad_pkg::OP_INC, 2'h1, 4'h6, 4'h0, 1'b1, 32'h2, 35'h0_0000_a55b);
    c(dmad_pkg::OP_DEC, 2'h0, 4'ha, 4'h0, 1'b1, 32'h1, 35'h0);
    c(dmad_pkg::OP_ADD_SMALL, 2'h2, 4'h6, 4'h0, 1'b1, 32'h4, 35'h0_1234_a55f);
    c(dmad_pkg::OP_SUB_SMALL, 2'h2, 4'h6, 4'h0, 1'b1, 32'h1, 35'h0_1234_a55e);
    c(dmad_pkg::OP_MOVE_IMM, 2'h0, 4'ha, 4'h0, 1'b1, 32'h09, 35'h09);
    c(dmad_pkg::OP_ADD, 2'h0, 4'ha, 4'h0, 1'b1, 32'h1, 35'h0a);
    c(dmad_pkg::OP_DADJ_ADD, 2'h0, 4'ha, 4'h0, 1'b0, 32'h0, 35'h10);
    c(dmad_pkg::OP_SUB_B, 2'h0, 4'ha, 4'h0, 1'b1, 32'h1, 35'h4_0000_000f);
    c(dmad_pkg::OP_DADJ_SUB, 2'h0, 4'ha, 4'h0, 1'b0, 32'h0, 35'h09);
    ml(4'h4, 32'hff);
    ml(4'h5, 32'hff);
    c(dmad_pkg::OP_MUL_U, 2'h0, 4'h4, 4'hd, 1'b0, 32'h0, 35'hfe01);
    ml(4'h4, 32'hff);
    c(dmad_pkg::OP_MUL_S, 2'h0, 4'h4, 4'hd, 1'b0, 32'h0, 35'h1);
    ml(4'h4, 32'hffff);
    c(dmad_pkg::OP_MUL_S, 2'h1, 4'h4, 4'h5, 1'b0, 32'h0, 35'h0_ffff_ff01);
    $display("test arithmetic done");
    c(dmad_pkg::OP_PERIPH_FROM, 2'h0, 4'h9, 4'h0, 1'b0, 32'h0, 35'h1_0000_0000);
    c(dmad_pkg::OP_PERIPH_TO, 2'h0, 4'h9, 4'h0, 1'b0, 32'h0, 35'h1_0000_0000);
    c(dmad_pkg::OP_SUB, 2'h0, 4'h6, 4'h0, 1'b1, 32'h1, 35'h1_0000_0000);
    c(dmad_pkg::OP_INC, 2'h0, 4'h6, 4'h0, 1'b1, 32'h2, 35'h1_0000_0000);
    c(dmad_pkg::OP_ADD_SMALL, 2'h1, 4'h6, 4'h0, 1'b1, 32'h1, 35'h1_0000_0000);
    c(dmad_pkg::OP_ADD_C, 2'h1, 4'h6, 4'h0, 1'b1, 32'h1, 35'h1_0000_0000);
    c(dmad_pkg::OP_MUL_U, 2'h2, 4'h6, 4'h5, 1'b0, 32'h0, 35'h1_0000_0000);
    c(dmad_pkg::OP_POP, 2'h0, 4'h6, 4'h0, 1'b0, 32'h0, 35'h1_0000_0000);
    c(dmad_pkg::OP_MOVE_RR, 2'h2, 4'h0, 4'h6, 1'b0, 32'h0, 35'h0_1234_a55e);
    $display("test refusals done");
    ml(4'h7, 32'h1000);
    exp_addr = 32'h0ffc;
    exp_we = 3'h6;
    c(dmad_pkg::OP_PUSH, 2'h2, 4'h0, 4'h6, 1'b0, 32'h0, 35'h0_1234_a55e);
    exp_we = 3'h1;
    pop_data = 32'h8001;
    c(dmad_pkg::OP_POP, 2'h1, 4'h2, 4'h0, 1'b0, 32'h0, 35'h8001);
    c(dmad_pkg::OP_MOVE_RR, 2'h2, 4'h0, 4'h7, 1'b0, 32'h0, 35'h0ffe);
    @(posedge clk) am <= dmad_pkg::AM_DISP;
    c(dmad_pkg::OP_MOVE_LD, 2'h1, 4'h2, 4'h0, 1'b1, 32'hfffe, 35'h8001);
    $display("test stack done");
    repeat (2) @(posedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
